/* hdl/svd_ctrl.sv */
/*
 * Control and flag logic of the supply voltage detector: register port, reference settle
 * wait, direction qualified event flag, interrupt gating and analog steering outputs.
 * Assumes the comparator and band-gap levels are synchronous to sys_clk_i and that the
 * analog divider, reference and input multiplexer sit outside this block.
 */
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module svd_ctrl
#(
   parameter int unsigned SETTLE_CYC = svd_pkg::SETTLE_CYCLES
)
(
   // Clock and reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  sys_rst_i,
   // Register port
   input  wire svd_pkg::svd_bus_req_t bus_req_i,
   output logic [31:0]                rdata_o,
   // Analog side
   input  wire svd_pkg::svd_ana_in_t  ana_i,
   output svd_pkg::svd_ana_out_t      ana_o,
   // Interrupts and wake
   output logic                       vector_irq_o,
   output logic                       irq_o,
   output logic                       wake_o
);
   import svd_pkg::*;

   logic [7:0]       ctrl_reg;
   logic             ref_stable;
   logic             settle_done;
   logic             bandgap_reg;
   logic             bandgap_prev_reg;
   logic             ref_prev_reg;
   logic             flag_reg;
   logic             flag_next;
   logic             int_en_reg;
   logic             global_en_reg;
   logic             ext_sel_reg;
   logic [IRQ_W-1:0] irq_en_reg;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;
   logic             detector_enable;
   logic             direction_select;
   logic [3:0]       trip_level_field;
   logic             crossing;
   logic             wr_ctrl;
   logic             wr_flag;
   logic [31:0]      rdata_next;

   assign detector_enable  = ctrl_reg[BIT_ENABLE];
   assign direction_select = ctrl_reg[BIT_DIRECTION];
   assign trip_level_field = ctrl_reg[LEVEL_MSB:0];
   assign wr_ctrl          = bus_req_i.wr && (bus_req_i.addr == OFS_CONTROL);
   assign wr_flag          = bus_req_i.wr && (bus_req_i.addr == OFS_PERIPH_FLG);

   // Only the enable, direction and level bits take writes; the two stable bits are status.
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         ctrl_reg <= CONTROL_RESET;
      else if (wr_ctrl)
         ctrl_reg <= bus_req_i.wdata[7:0] & CONTROL_WMASK;
   end

   svd_settle_timer
   #(
      .CYCLES (SETTLE_CYC)
   )
   u_settle
   (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .enable_i  (detector_enable),
      .stable_o  (settle_done)
   );

   // The timer still reports stable for one cycle after the enable drops, so the status
   // bit and the event gate are masked by the live enable as well.
   assign ref_stable = settle_done && detector_enable;

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         bandgap_reg      <= 1'b0;
         bandgap_prev_reg <= 1'b0;
         ref_prev_reg     <= 1'b0;
      end
      else
      begin
         bandgap_reg      <= ana_i.bandgap_ok;
         bandgap_prev_reg <= bandgap_reg;
         ref_prev_reg     <= ref_stable;
      end
   end

   // The comparator is trusted only once the reference has settled after this enable.
   always_comb
   begin
      crossing = 1'b0;
      if (detector_enable && ref_stable)
      begin
         if (direction_select)
            crossing = ana_i.at_or_above;
         else
            crossing = ana_i.at_or_below;
      end
   end

   // Software may only clear the flag; a crossing in the same cycle keeps it set.
   always_comb
   begin
      flag_next = flag_reg;
      if (wr_flag && !bus_req_i.wdata[BIT_EVENT])
         flag_next = 1'b0;
      if (crossing)
         flag_next = 1'b1;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         flag_reg <= 1'b0;
      else
         flag_reg <= flag_next;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         int_en_reg    <= 1'b0;
         global_en_reg <= 1'b0;
         irq_en_reg    <= '0;
      end
      else if (bus_req_i.wr)
      begin
         if (bus_req_i.addr == OFS_PERIPH_ENA)
            int_en_reg <= bus_req_i.wdata[BIT_EVENT];
         if (bus_req_i.addr == OFS_INT_CTRL)
            global_en_reg <= bus_req_i.wdata[BIT_GLOBAL_EN];
         if (bus_req_i.addr == OFS_IRQ_ENABLE)
            irq_en_reg <= bus_req_i.wdata[IRQ_W-1:0];
      end
   end

   assign irq_set[IRQ_CROSSING]  = crossing;
   assign irq_set[IRQ_REF_READY] = ref_stable && !ref_prev_reg;
   assign irq_set[IRQ_BG_READY]  = bandgap_reg && !bandgap_prev_reg;
   assign irq_clr = (bus_req_i.wr && (bus_req_i.addr == OFS_IRQ_CLEAR)) ?
                    bus_req_i.wdata[IRQ_W-1:0] : '0;

   svd_sticky_bits
   #(
      .W (IRQ_W)
   )
   u_status
   (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .set_i     (irq_set),
      .clr_i     (irq_clr),
      .q_o       (irq_status)
   );

   // The divider tap select is ignored by the analog side while the external input is chosen.
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         ext_sel_reg <= 1'b0;
      else
         ext_sel_reg <= (trip_level_field == LEVEL_EXTERNAL);
   end

   assign ana_o.power_en   = detector_enable;
   assign ana_o.direction  = direction_select;
   assign ana_o.ext_select = ext_sel_reg;
   assign ana_o.level      = trip_level_field;

   // Wake follows the flag alone so a sleeping core restarts even with interrupts masked.
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         vector_irq_o <= 1'b0;
         irq_o        <= 1'b0;
         wake_o       <= 1'b0;
      end
      else
      begin
         vector_irq_o <= flag_reg && int_en_reg && global_en_reg;
         irq_o        <= |(irq_status & irq_en_reg);
         wake_o       <= flag_reg;
      end
   end

   always_comb
   begin
      rdata_next = '0;
      if (bus_req_i.rd)
      begin
         unique case (bus_req_i.addr)
            OFS_CONTROL:
            begin
               rdata_next[7:0]            = ctrl_reg;
               rdata_next[BIT_BANDGAP_OK] = bandgap_reg;
               rdata_next[BIT_REF_STABLE] = ref_stable;
            end
            OFS_PERIPH_FLG: rdata_next[BIT_EVENT]     = flag_reg;
            OFS_PERIPH_ENA: rdata_next[BIT_EVENT]     = int_en_reg;
            OFS_INT_CTRL:   rdata_next[BIT_GLOBAL_EN] = global_en_reg;
            OFS_IRQ_STATUS: rdata_next[IRQ_W-1:0]     = irq_status;
            OFS_IRQ_ENABLE: rdata_next[IRQ_W-1:0]     = irq_en_reg;
            default:        rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         rdata_o <= '0;
      else
         rdata_o <= rdata_next;
   end

   // Helper: cycles the enable has been held, saturating.
   logic [CNT_W-1:0] en_age;

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i || !detector_enable)
         en_age <= '0;
      else if (en_age != {CNT_W{1'b1}})
         en_age <= en_age + CNT_W'(1);
   end

   a_power_follows_en: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      wr_ctrl |=> (ana_o.power_en == $past(bus_req_i.wdata[BIT_ENABLE])))
      else $error("detector power does not follow the written enable");

   a_ref_not_early: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      ref_stable |-> (detector_enable && (en_age >= CNT_W'(SETTLE_CYC))))
      else $error("reference stable raised before the settle time");

   a_ref_not_late: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (detector_enable && (en_age >= CNT_W'(SETTLE_CYC))) |-> ref_stable)
      else $error("reference stable missing after the settle time");

   a_no_flag_unsettled: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(flag_reg) |-> $past(ref_stable && detector_enable))
      else $error("event flag set before the reference settled");

   a_low_dir_sets: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (ref_stable && detector_enable && !direction_select && ana_i.at_or_below)
      |=> flag_reg ##1 wake_o)
      else $error("low crossing did not set the flag and wake");

   a_high_dir_sets: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (ref_stable && detector_enable && direction_select && ana_i.at_or_above) |=> flag_reg)
      else $error("high crossing did not set the flag");

   a_wrong_dir_quiet: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(flag_reg) |-> $past(direction_select ? ana_i.at_or_above : ana_i.at_or_below))
      else $error("flag set by a crossing in the other direction");

   a_ext_input_mode: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      ##1 (ana_o.ext_select == ($past(trip_level_field) == LEVEL_EXTERNAL)))
      else $error("external input select does not match level code");

   a_bandgap_bit: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (bus_req_i.rd && (bus_req_i.addr == OFS_CONTROL))
      |=> (rdata_o[BIT_BANDGAP_OK] == $past(bandgap_reg)))
      else $error("band-gap stable bit reads wrong");

   a_vector_gate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      vector_irq_o == $past(flag_reg && int_en_reg && global_en_reg))
      else $error("vector request not gated by both enables");

   a_flag_sticky: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (flag_reg && !(wr_flag && !bus_req_i.wdata[BIT_EVENT])) |=> flag_reg)
      else $error("event flag dropped without a software clear");

   a_reset_off: assert property (@(posedge sys_clk_i)
      sys_rst_i |=> (!ana_o.power_en && (ana_o.level == CONTROL_RESET[3:0])))
      else $error("detector not off after reset");

   a_dir_follows_wr: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      wr_ctrl |=> (ana_o.direction == $past(bus_req_i.wdata[BIT_DIRECTION])))
      else $error("direction output does not follow the written bit");

   a_level_follows_wr: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      wr_ctrl |=> (ana_o.level == $past(bus_req_i.wdata[LEVEL_MSB:0])))
      else $error("level output does not follow the written field");

   a_ref_bit_read: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (bus_req_i.rd && (bus_req_i.addr == OFS_CONTROL))
      |=> (rdata_o[BIT_REF_STABLE] == $past(ref_stable)))
      else $error("reference stable bit reads wrong");

   a_no_flag_disabled: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (!detector_enable && !flag_reg) |=> !flag_reg)
      else $error("event flag set while the detector is off");

   a_flag_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (wr_flag && !bus_req_i.wdata[BIT_EVENT] && !crossing) |=> !flag_reg)
      else $error("software clear of the event flag ignored");

   a_wake_follows_flag: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      wake_o == $past(flag_reg))
      else $error("wake output does not follow the event flag");

   a_crossing_status: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      crossing |=> irq_status[IRQ_CROSSING])
      else $error("crossing did not set its status bit");

   a_ref_ready_status: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (ref_stable && !ref_prev_reg) |=> irq_status[IRQ_REF_READY])
      else $error("reference ready did not set its status bit");

   a_status_sticky: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (irq_status[IRQ_CROSSING] && !irq_clr[IRQ_CROSSING]) |=> irq_status[IRQ_CROSSING])
      else $error("crossing status dropped without a clear");

   a_irq_masked: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (irq_en_reg == '0) |=> !irq_o)
      else $error("interrupt raised with every status bit masked");

   a_irq_raised: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (irq_status[IRQ_CROSSING] && irq_en_reg[IRQ_CROSSING]) |=> irq_o)
      else $error("enabled crossing status did not raise the interrupt");

   a_read_data_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !bus_req_i.rd |=> (rdata_o == 32'h0))
      else $error("read data stands outside the cycle after a read");

   c_low_event: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(flag_reg) && !direction_select);
   c_high_event: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(flag_reg) && direction_select);
   c_vector: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(vector_irq_o));
   c_external: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      ana_o.ext_select && $rose(flag_reg));
   c_ref_ready: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(ref_stable));
endmodule

/* hdl/svd_pkg.sv */
/*
 * Constants, register map and carrier types of the supply voltage detect control block.
 * Assumes a 200 MHz system clock and a synchronous, active-high reset.
 */
// Function
// - Bit 4 of the control register powers the detector while it is set and turns it off when cleared.
// - After every enable the read-only reference-stable bit 5 stays low until the settle time passes, then reads one.
// - The detect event flag cannot be set before the reference-stable bit has been set since the enable.
// - Direction bit 7 at zero flags the supply at or below the trip point, at one at or above it.
// - A comparator report of the trip point reached in the chosen direction sets the detect event flag.
// - The 4-bit level field at bits 3 to 0 picks one of fifteen trip levels, 0000 lowest and 1110 highest.
// - Level code 1111 steers the comparator to the external trip input instead of the divider tap.
// - Read-only bit 6 reads one once the band-gap reference reports stable.
// - The flag sits at bit 2 of the flag register, its enable at bit 2 of the enable register, and the vector request needs both that enable and the global enable at bit 7.
// - While enabled the detector keeps working in sleep, and a qualifying crossing sets the flag and wakes the device.
// - Reset returns the control register to its reset value, which leaves the detector off.
package svd_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_CONTROL    = 8'h00;
   localparam logic [7:0] OFS_PERIPH_FLG = 8'h04;
   localparam logic [7:0] OFS_PERIPH_ENA = 8'h08;
   localparam logic [7:0] OFS_INT_CTRL   = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h14;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
   // Control register fields.
   localparam int         BIT_DIRECTION  = 7;
   localparam int         BIT_BANDGAP_OK = 6;
   localparam int         BIT_REF_STABLE = 5;
   localparam int         BIT_ENABLE     = 4;
   localparam int         LEVEL_MSB      = 3;
   localparam logic [3:0] LEVEL_EXTERNAL = 4'hf;
   localparam logic [7:0] CONTROL_RESET  = 8'h05;
   localparam logic [7:0] CONTROL_WMASK  = 8'h9f;
   // Flag, enable and global enable positions.
   localparam int         BIT_EVENT      = 2;
   localparam int         BIT_GLOBAL_EN  = 7;
   // Sticky interrupt status bits.
   localparam int         IRQ_W          = 3;
   localparam int         IRQ_CROSSING   = 0;
   localparam int         IRQ_REF_READY  = 1;
   localparam int         IRQ_BG_READY   = 2;
   // Reference settle time.
   localparam int         SETTLE_TIME_NS = 1000;
   localparam int         CLK_PERIOD_PS  = 5000;
   localparam int         SETTLE_CYCLES  = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int         CNT_W          = 16;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } svd_bus_req_t;

   typedef struct packed {
      logic at_or_above;
      logic at_or_below;
      logic bandgap_ok;
   } svd_ana_in_t;

   typedef struct packed {
      logic       power_en;
      logic       direction;
      logic       ext_select;
      logic [3:0] level;
   } svd_ana_out_t;
endpackage

/* hdl/svd_settle_timer.sv */
/*
 * Reference settle timer: counts clock cycles from each enable and then reports stable.
 * Assumes the enable comes from a flip-flop in the same clock domain.
 */
`timescale 1ns/1ps
module svd_settle_timer
#(
   parameter int unsigned CYCLES = 200
)
(
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic sys_rst_i,
   // Control and status
   input  wire logic enable_i,
   output logic      stable_o
);
   import svd_pkg::*;

   logic [CNT_W-1:0] cnt_reg;

   // Dropping the enable restarts the wait, so each enable pays the full settle time.
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i || !enable_i)
      begin
         cnt_reg  <= '0;
         stable_o <= 1'b0;
      end
      else if (cnt_reg == CNT_W'(CYCLES - 1))
      begin
         stable_o <= 1'b1;
      end
      else
      begin
         cnt_reg <= cnt_reg + CNT_W'(1);
      end
   end
endmodule

/* hdl/svd_sticky_bits.sv */
/*
 * Row of sticky status bits: a set pulse holds a bit until a clear request.
 * Assumes set and clear are one-cycle requests in the same clock domain.
 */
`timescale 1ns/1ps
module svd_sticky_bits
#(
   parameter int W = 3
)
(
   // Clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         sys_rst_i,
   // Requests and state
   input  wire logic [W-1:0] set_i,
   input  wire logic [W-1:0] clr_i,
   output logic      [W-1:0] q_o
);
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         // A set in the same cycle as a clear wins, so no event is lost.
         always_ff @(posedge sys_clk_i)
         begin
            if (sys_rst_i)
               q_o[i] <= 1'b0;
            else if (set_i[i])
               q_o[i] <= 1'b1;
            else if (clr_i[i])
               q_o[i] <= 1'b0;
         end
      end
   endgenerate
endmodule

/* verif/svd_ana_model.sv */
/*
 * Behavioural model of the analog side: supply comparator, divider taps, external trip
 * input and band-gap reference. Assumes the bench sets the supply and external voltages
 * in millivolts and that the block steers the model through its analog output struct.
 */
`timescale 1ns/1ps
module svd_ana_model
#(
   parameter int BASE_MV = 1800,
   parameter int STEP_MV = 100,
   parameter int REF_MV  = 1024,
   parameter int BG_CYC  = 6
)
(
   // Clock and reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  sys_rst_i,
   // Steering from the block
   input  wire svd_pkg::svd_ana_out_t steer_i,
   // Voltages set by the bench
   input  wire logic [15:0]           supply_mv_i,
   input  wire logic [15:0]           ext_mv_i,
   // Comparator and band-gap levels
   output svd_pkg::svd_ana_in_t       cmp_o
);
   import svd_pkg::*;
   int bg_cnt;
   int in_mv;
   int trip_mv;

   always_comb
   begin
      in_mv   = steer_i.ext_select ? int'(ext_mv_i) : int'(supply_mv_i);
      trip_mv = steer_i.ext_select ? REF_MV : BASE_MV + STEP_MV * int'(steer_i.level);
   end

   // An unpowered comparator output is not trustworthy, so it toggles every cycle.
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         bg_cnt <= 0;
         cmp_o  <= '0;
      end
      else
      begin
         if (bg_cnt < BG_CYC)
            bg_cnt <= bg_cnt + 1;
         cmp_o.bandgap_ok <= (bg_cnt == BG_CYC);
         if (steer_i.power_en)
         begin
            cmp_o.at_or_above <= (in_mv >= trip_mv);
            cmp_o.at_or_below <= (in_mv <= trip_mv);
         end
         else
         begin
            cmp_o.at_or_above <= ~cmp_o.at_or_above;
            cmp_o.at_or_below <= ~cmp_o.at_or_below;
         end
      end
   end
endmodule

/* verif/svd_ctrl_tb_top.sv */
/*
 * Self-checking testbench of the voltage detect control block with the analog model.
 * Assumes a shortened settle count and drives the register port by non-blocking writes.
 */
`timescale 1ns/1ps
module svd_ctrl_tb_top;
   import svd_pkg::*;
   localparam int SETTLE  = 8;
   localparam int BASE_MV = 1800;
   localparam int STEP_MV = 100;
   localparam int REF_MV  = 1024;
   logic          sys_clk_i = 1'b0;
   logic          sys_rst_i = 1'b1;
   svd_bus_req_t  req       = '0;
   logic [31:0]   rdata_o;
   svd_ana_in_t   ana_i;
   svd_ana_out_t  ana_o;
   logic          vector_irq_o;
   logic          irq_o;
   logic          wake_o;
   logic [15:0]   supply_mv = 16'h0bb8;
   logic [15:0]   ext_mv    = 16'h0000;
   int            n_errors  = 0;
   int            n_checks  = 0;

   always #2.5 sys_clk_i = ~sys_clk_i;

   svd_ctrl #(.SETTLE_CYC(SETTLE)) uut (
      .sys_clk_i    (sys_clk_i),
      .sys_rst_i    (sys_rst_i),
      .bus_req_i    (req),
      .rdata_o      (rdata_o),
      .ana_i        (ana_i),
      .ana_o        (ana_o),
      .vector_irq_o (vector_irq_o),
      .irq_o        (irq_o),
      .wake_o       (wake_o)
   );

   svd_ana_model #(.BASE_MV(BASE_MV), .STEP_MV(STEP_MV), .REF_MV(REF_MV)) ana_model (
      .sys_clk_i   (sys_clk_i),
      .sys_rst_i   (sys_rst_i),
      .steer_i     (ana_o),
      .supply_mv_i (supply_mv),
      .ext_mv_i    (ext_mv),
      .cmp_o       (ana_i)
   );

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      req.addr  <= a;
      req.wdata <= d;
      req.wr    <= 1'b1;
      @(posedge sys_clk_i);
      req.wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so they are taken there.
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk_i);
      req.addr <= a;
      req.rd   <= 1'b1;
      @(posedge sys_clk_i);
      req.rd   <= 1'b0;
      #1;
      chk_word(rdata_o, exp);
   endtask

   // Level code 1111 moves the trip to the external input; the unused source sits on its
   // own trip point so that wrong steering would raise a flag.
   task automatic set_v(input logic ext, input int v);
      @(posedge sys_clk_i);
      supply_mv <= ext ? 16'(BASE_MV + STEP_MV * 15) : 16'(v);
      ext_mv    <= ext ? 16'(v) : 16'(REF_MV);
   endtask

   task automatic t_reset;
      rd_chk(OFS_CONTROL, 32'h05);
      chk_bit(ana_o.power_en, 1'b0);
      chk_word({28'h0, ana_o.level}, 32'h5);
      cyc(10);
      rd_chk(OFS_CONTROL, 32'h45);
      $display("test reset done, errors %0d", n_errors);
   endtask

   task automatic t_settle;
      set_v(1'b0, BASE_MV + STEP_MV * 3 - 50);
      bus_wr(OFS_CONTROL, 32'h13);
      cyc(1);
      chk_bit(ana_o.power_en, 1'b1);
      rd_chk(OFS_CONTROL, 32'h53);
      rd_chk(OFS_PERIPH_FLG, 32'h0);
      cyc(SETTLE + 4);
      rd_chk(OFS_CONTROL, 32'h73);
      rd_chk(OFS_PERIPH_FLG, 32'h4);
      $display("test settle done, errors %0d", n_errors);
   endtask

   task automatic t_sticky;
      set_v(1'b0, BASE_MV + STEP_MV * 3 + 50);
      cyc(4);
      rd_chk(OFS_PERIPH_FLG, 32'h4);
      bus_wr(OFS_PERIPH_FLG, 32'h4);
      rd_chk(OFS_PERIPH_FLG, 32'h4);
      bus_wr(OFS_PERIPH_FLG, 32'h0);
      rd_chk(OFS_PERIPH_FLG, 32'h0);
      $display("test sticky done, errors %0d", n_errors);
   endtask

   task automatic t_level(input logic [3:0] lv, input logic dir);
      logic ext;
      int   thr;
      int   off;
      ext = (lv === 4'hf);
      thr = ext ? REF_MV : BASE_MV + STEP_MV * int'(lv);
      off = dir ? -1 : 1;
      bus_wr(OFS_CONTROL, {24'h0, 4'h0, lv});
      bus_wr(OFS_CONTROL, {24'h0, dir, 3'h0, lv});
      bus_wr(OFS_CONTROL, {24'h0, dir, 3'h1, lv});
      set_v(ext, thr + off);
      cyc(2);
      chk_word({28'h0, ana_o.level}, {28'h0, lv});
      chk_bit(ana_o.ext_select, ext);
      chk_bit(ana_o.direction, dir);
      cyc(SETTLE + 4);
      bus_wr(OFS_PERIPH_FLG, 32'h0);
      cyc(4);
      rd_chk(OFS_PERIPH_FLG, 32'h0);
      set_v(ext, thr);
      cyc(4);
      rd_chk(OFS_PERIPH_FLG, 32'h4);
      set_v(ext, thr + off);
      cyc(4);
      bus_wr(OFS_PERIPH_FLG, 32'h0);
   endtask

   task automatic t_irq;
      bus_wr(OFS_CONTROL, 32'h03);
      bus_wr(OFS_CONTROL, 32'h13);
      set_v(1'b0, BASE_MV);
      cyc(SETTLE + 6);
      chk_bit(wake_o, 1'b1);
      chk_bit(vector_irq_o, 1'b0);
      bus_wr(OFS_PERIPH_ENA, 32'h4);
      cyc(2);
      chk_bit(vector_irq_o, 1'b0);
      bus_wr(OFS_INT_CTRL, 32'h80);
      cyc(2);
      chk_bit(vector_irq_o, 1'b1);
      bus_wr(OFS_PERIPH_ENA, 32'h0);
      cyc(2);
      chk_bit(vector_irq_o, 1'b0);
      rd_chk(OFS_IRQ_STATUS, 32'h7);
      chk_bit(irq_o, 1'b0);
      bus_wr(OFS_IRQ_ENABLE, 32'h1);
      cyc(2);
      chk_bit(irq_o, 1'b1);
      bus_wr(OFS_IRQ_ENABLE, 32'h0);
      cyc(2);
      chk_bit(irq_o, 1'b0);
      set_v(1'b0, BASE_MV + STEP_MV * 9);
      cyc(4);
      bus_wr(OFS_PERIPH_FLG, 32'h0);
      bus_wr(OFS_IRQ_CLEAR, 32'h7);
      cyc(2);
      chk_bit(wake_o, 1'b0);
      rd_chk(OFS_IRQ_STATUS, 32'h0);
      rd_chk(OFS_IRQ_CLEAR, 32'h0);
      bus_wr(8'h1c, 32'hffffffff);
      rd_chk(8'h1c, 32'h0);
      $display("test irq done, errors %0d", n_errors);
   endtask

   task automatic t_disable;
      bus_wr(OFS_CONTROL, 32'h03);
      cyc(2);
      chk_bit(ana_o.power_en, 1'b0);
      rd_chk(OFS_CONTROL, 32'h43);
      set_v(1'b0, BASE_MV);
      cyc(SETTLE + 6);
      rd_chk(OFS_PERIPH_FLG, 32'h0);
      bus_wr(OFS_CONTROL, 32'h93);
      @(posedge sys_clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      cyc(1);
      chk_bit(ana_o.power_en, 1'b0);
      chk_word({28'h0, ana_o.level}, 32'h5);
      rd_chk(OFS_CONTROL, 32'h05);
      $display("test disable done, errors %0d", n_errors);
   endtask

   task automatic test_done;
      $display("checks %0d, errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      repeat (8) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_settle();
      t_sticky();
      for (int i = 0; i < 32; i++)
         t_level(4'(i), i[4]);
      $display("test level done, errors %0d", n_errors);
      t_irq();
      t_disable();
      test_done();
   end

   // All tests take about 1500 cycles; this limit of 40000 cycles is over twenty times that.
   initial
   begin
      #200000;
      n_errors++;
      test_done();
   end
endmodule
